// ==== analog_control_register_bank.sv ====
`timescale 1ns/10ps
`include "analog_ctrl_defines.svh"
module analog_control_register_bank
  import analog_ctrl_pkg::*;
#(
  parameter int SETTLE_CYCLES = (`SENSOR_SETTLE_MS * 1000000) / `CLK_PERIOD_NS
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  input  wire logic        global_write_protect,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_hit,
  output ramp_cfg_t        ramp_cfg,
  output supply_cfg_t      supply_cfg
);
  localparam int FLY_SHORT = (`FLYBACK_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int FLY_LONG  = (`FLYBACK_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  logic        in_range;
  logic [3:0]  idx;
  logic        wr_ok;
  logic [71:0] regs;
  logic [7:0]  r_ramp, r_amp, r_peak, r_bias, r_gamma, r_mode, r_conv, r_vmax, r_man;
  logic [2:0]  code_prev_ff;
  logic [23:0] settle_cnt_ff;
  logic [23:0] nxt_settle_cnt;
  logic        settled_ff;

  assign in_range = reg_addr >= `ADDR_RAMP_CONTROL && reg_addr <= `ADDR_CATHODE_MANUAL;
  assign idx      = 4'(reg_addr - `ADDR_FIRST);
  assign reg_hit  = in_range;
  // RL22 writes blocked while protected
  assign wr_ok    = reg_wr && in_range && !global_write_protect;

  analog_ctrl_regfile #(.NREGS(`NUM_REGS)) u_regs (
    .clk        (clk),
    .nrst       (nrst),
    .clk_en     (clk_en),
    .wr_en      (wr_ok),
    .wr_idx     (idx),
    .wr_data    (reg_wdata),
    .rd_idx     (in_range ? idx : 4'hF),
    .rd_data_ff (reg_rdata),
    .regs_flat  (regs)
  );

  assign r_ramp  = regs[7:0];
  assign r_amp   = regs[15:8];
  assign r_peak  = regs[23:16];
  assign r_bias  = regs[31:24];
  assign r_gamma = regs[39:32];
  assign r_mode  = regs[47:40];
  assign r_conv  = regs[55:48];
  assign r_vmax  = regs[63:56];
  assign r_man   = regs[71:64];

  always_comb begin
    // RL1 power save
    ramp_cfg.counter_power_save        = r_ramp[4];
    // RL2 force high test
    ramp_cfg.ramp_force_high           = r_ramp[3];
    // RL3 flyback select
    ramp_cfg.flyback_time_select       = r_ramp[2];
    ramp_cfg.flyback_cycles            = r_ramp[2] ? 10'(FLY_LONG) : 10'(FLY_SHORT);
    // RL4 ramp start shift
    ramp_cfg.ramp_start_shift          = r_ramp[1:0];
    // RL5 monitor enables
    ramp_cfg.amp_output_monitor_en     = r_amp[4];
    ramp_cfg.ramp_converter_monitor_en = r_amp[3];
    // RL6 bias current
    ramp_cfg.amp_bias_current          = r_amp[2:0];
    // RL7 peak scale
    ramp_cfg.ramp_peak_scale           = r_peak;
    // RL8 pixel bias
    ramp_cfg.external_reference_select = r_bias[2];
    ramp_cfg.pixel_sink_current        = r_bias[1:0];
  end

  // RL12 settle timer after current code change, advisory for the host
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      code_prev_ff <= 3'h0;
    end else if (clk_en) begin
      code_prev_ff <= r_gamma[2:0];
    end
  end

  always_comb begin
    nxt_settle_cnt = settle_cnt_ff;
    if (code_prev_ff != r_gamma[2:0]) begin
      nxt_settle_cnt = 24'(SETTLE_CYCLES);
    end else if (settle_cnt_ff != 24'h000000) begin
      nxt_settle_cnt = settle_cnt_ff - 24'h000001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settle_cnt_ff <= 24'h000000;
      settled_ff    <= 1'b1;
    end else if (clk_en) begin
      settle_cnt_ff <= nxt_settle_cnt;
      settled_ff    <= (nxt_settle_cnt == 24'h000000);
    end
  end

  always_comb begin
    // RL9 converter hold
    supply_cfg.converter_hold_en     = r_gamma[4];
    // RL10 sample hold
    supply_cfg.sensor_sample_hold_en = r_gamma[3];
    // RL11 current divider
    supply_cfg.sensor_current_code   = r_gamma[2:0];
    supply_cfg.sensor_current_onehot = 8'h01 << r_gamma[2:0];
    supply_cfg.sensor_settled        = settled_ff;
    // RL13 converter mode
    supply_cfg.cathode_mode_field    = cathode_mode_t'(r_mode[1:0]);
    supply_cfg.current_sensor_en     = r_mode[3:2];
    // RL14 auto one regulates current
    supply_cfg.regulate_current      = r_mode[1:0] == 2'h0 || r_mode[1:0] == 2'h1;
    // RL15 auto two clamps
    supply_cfg.clamp_at_level        = r_mode[1:0] == 2'h1;
    // RL16 manual level use
    supply_cfg.use_manual_level      = r_mode[1:0] == 2'h1 || r_mode[1:0] == 2'h2;
    supply_cfg.cathode_manual_level  = r_man;
    // RL17 soft start disable
    supply_cfg.soft_start_disable    = r_conv[7];
    // RL18 clock duty
    supply_cfg.converter_clock_duty  = r_conv[6:4];
    supply_cfg.duty_code_illegal     = r_conv[6:4] == 3'h7;
    // RL19 clock frequency
    supply_cfg.converter_clock_freq  = r_conv[3:2];
    // RL20 soft start duration
    supply_cfg.soft_start_duration   = r_conv[1:0];
    // RL21 max pixel voltage
    supply_cfg.max_pixel_voltage     = r_vmax;
  end

  a_protect_holds: assert property (@(posedge clk) disable iff (!nrst)
    global_write_protect && clk_en |=> $stable(regs)) // RL22
    else $error("register changed while write protected");

  a_write_lands: assert property (@(posedge clk) disable iff (!nrst)
    wr_ok && clk_en && reg_addr == `ADDR_CATHODE_MANUAL
    |=> supply_cfg.cathode_manual_level == $past(reg_wdata)) // RL16
    else $error("manual level write lost");

  a_ramp_zero_bits: assert property (@(posedge clk) disable iff (!nrst)
    r_ramp[7:5] == 3'h0 && r_bias[7:3] == 5'h00 && r_gamma[7:5] == 3'h0) // RL23
    else $error("unassigned bit set");

  a_flyback_count: assert property (@(posedge clk) disable iff (!nrst)
    ramp_cfg.flyback_cycles == (r_ramp[2] ? 10'd20 : 10'd13)) // RL3
    else $error("flyback count wrong");

  a_clamp_mode: assert property (@(posedge clk) disable iff (!nrst)
    supply_cfg.clamp_at_level |-> supply_cfg.use_manual_level
      && supply_cfg.regulate_current) // RL15
    else $error("mode two decode wrong");

  a_sensor_div: assert property (@(posedge clk) disable iff (!nrst)
    supply_cfg.sensor_current_onehot[r_gamma[2:0]]
      && $onehot(supply_cfg.sensor_current_onehot)) // RL11
    else $error("sensor divider decode wrong");

  a_settle_start: assert property (@(posedge clk) disable iff (!nrst)
    clk_en && $changed(r_gamma[2:0]) ##1 clk_en |=> !settled_ff) // RL12
    else $error("settle flag not cleared");

  a_soft_start: assert property (@(posedge clk) disable iff (!nrst)
    supply_cfg.soft_start_disable == r_conv[7]
      && supply_cfg.converter_hold_en == r_gamma[4]) // RL17
    else $error("converter control decode wrong");

  a_mode_one: assert property (@(posedge clk) disable iff (!nrst)
    r_mode[1:0] == 2'h0 |-> supply_cfg.regulate_current
      && !supply_cfg.use_manual_level) // RL14
    else $error("mode one decode wrong");
endmodule : analog_control_register_bank

// ==== analog_control_register_bank_test.sv ====
`timescale 1ns/10ps
module analog_control_register_bank_test;
  import analog_ctrl_pkg::*;
  localparam int SETTLE = 20;
  localparam logic [7:0] rst_v [9] = '{8'h01, 8'h04, 8'h00, 8'h01, 8'h00, 8'h00, 8'h3D,
                                       8'h0D, 8'h51};
  localparam logic [7:0] msk_v [9] = '{8'h1F, 8'h1F, 8'hFF, 8'h07, 8'h1F, 8'h0F, 8'hFF,
                                       8'hFF, 8'hFF};
  localparam logic [2:0] mode_v [4] = '{3'b100, 3'b111, 3'b001, 3'b000};
  logic        clk;
  logic        nrst;
  logic        clk_en;
  logic        global_write_protect;
  logic        reg_wr;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_hit;
  ramp_cfg_t   ramp_cfg;
  supply_cfg_t supply_cfg;
  logic [7:0]  rv;
  int          n;
  int          fail_count;
  int          checked;

  analog_control_register_bank #(.SETTLE_CYCLES(SETTLE)) dut (
    .clk(clk), .nrst(nrst), .clk_en(clk_en), .global_write_protect(global_write_protect),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .ramp_cfg(ramp_cfg), .supply_cfg(supply_cfg));

  cfg_host host (
    .clk(clk), .sensor_settled(supply_cfg.sensor_settled), .reg_rdata(reg_rdata),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  always #20 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic t_reset;
    for (int i = 0; i < 9; i++) begin
      host.rd(8'h06 + 8'(i), rv);
      chk(16'(rv), 16'(rst_v[i]));
    end
    chk(16'(ramp_cfg.flyback_cycles), 16'h000D);
    chk(16'(supply_cfg.sensor_settled), 16'h0001);
    $display("reset test done");
  endtask : t_reset

  task automatic t_fill(input logic [7:0] v);
    for (int i = 0; i < 9; i++) begin
      host.wr(8'h06 + 8'(i), v);
    end
    host.idle();
    for (int i = 0; i < 9; i++) begin
      host.rd(8'h06 + 8'(i), rv);
      chk(16'(rv), 16'(v & msk_v[i]));
    end
    chk(16'(ramp_cfg.flyback_cycles), v[2] ? 16'h0014 : 16'h000D);
    chk(16'({ramp_cfg.counter_power_save, ramp_cfg.ramp_force_high}), {14'h0, v[4:3]});
    chk(16'(supply_cfg.duty_code_illegal), 16'(v[6:4] == 3'h7));
    chk(16'({ramp_cfg.ramp_start_shift, ramp_cfg.amp_output_monitor_en,
             ramp_cfg.ramp_converter_monitor_en, ramp_cfg.amp_bias_current,
             ramp_cfg.external_reference_select, ramp_cfg.pixel_sink_current}),
        16'({v[1:0], v[4:3], v[2:0], v[2:0]}));
    chk(16'({supply_cfg.soft_start_disable, supply_cfg.converter_clock_duty,
             supply_cfg.converter_clock_freq, supply_cfg.soft_start_duration}),
        16'(v));
    chk({supply_cfg.max_pixel_voltage, supply_cfg.cathode_manual_level}, {v, v});
    chk(16'({supply_cfg.current_sensor_en, 2'(supply_cfg.cathode_mode_field)}),
        16'(v[3:0]));
    chk(16'(ramp_cfg.ramp_peak_scale), 16'(v));
    $display("fill test done");
  endtask : t_fill

  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      host.wr(8'h0B, 8'(m));
      chk(16'({supply_cfg.regulate_current, supply_cfg.clamp_at_level,
               supply_cfg.use_manual_level}), 16'(mode_v[m]));
      chk(16'(supply_cfg.cathode_mode_field), 16'(m));
    end
    host.idle();
    $display("mode test done");
  endtask : t_modes

  task automatic t_protect;
    host.wr(8'h0E, 8'hAA);
    chk(16'(supply_cfg.cathode_manual_level), 16'h00AA);
    global_write_protect = 1'b1;
    host.wr(8'h0E, 8'h55);
    global_write_protect = 1'b0;
    clk_en = 1'b0;
    host.wr(8'h0E, 8'h33);
    clk_en = 1'b1;
    host.rd(8'h0E, rv);
    chk(16'(rv), 16'h00AA);
    $display("protect test done");
  endtask : t_protect

  task automatic t_unmapped;
    host.wr(8'h05, 8'hAA);
    chk(16'(reg_hit), 16'h0000);
    host.wr(8'h0F, 8'hAA);
    chk(16'(reg_hit), 16'h0000);
    host.rd(8'h0F, rv);
    chk(16'(rv), 16'h0000);
    host.program_nominal();
    host.rd(8'h08, rv);
    chk(16'({rv, ramp_cfg.ramp_peak_scale}), 16'h7878);
    $display("unmapped test done");
  endtask : t_unmapped

  task automatic t_sensor;
    host.wr(8'h0A, 8'h1B);
    host.idle();
    chk(16'(supply_cfg.sensor_settled), 16'h0000);
    chk(16'({supply_cfg.converter_hold_en, supply_cfg.sensor_sample_hold_en,
             supply_cfg.sensor_current_code}), 16'h001B);
    host.wait_settled(n);
    // bounded wait ran out: report now
    chk(16'(n >= SETTLE - 3 && n <= SETTLE + 1), 16'h0001);
    if (n >= 100) begin
      stop_test();
    end
    $display("sensor test done");
  endtask : t_sensor

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    clk_en = 1'b1;
    global_write_protect = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_fill(8'hFF);
    t_fill(8'h00);
    t_modes();
    t_protect();
    t_unmapped();
    t_sensor();
    stop_test();
  end
endmodule : analog_control_register_bank_test

// ==== analog_ctrl_defines.svh ====
`ifndef ANALOG_CTRL_DEFINES_SVH
`define ANALOG_CTRL_DEFINES_SVH
// Behaviour
// RL1: ramp control bit 4 power save, reset 0, selects mixed 8/10-bit conversion.
// RL2: ramp control bit 3 forces ramp converter all-high for test, reset 0.
// RL3: ramp control bit 2 selects flyback 500 ns (0, reset) or 800 ns.
// RL4: ramp control bits 1-0 shift ramp start; 00 early, 01 none (reset), 10 late.
// RL5: amp register bit 4 output monitor, bit 3 converter monitor, both reset 0.
// RL6: amp register bits 2-0 bias current in 25% steps, reset 100 nominal.
// RL7: register 08h ramp peak scale, reset 0; host should program 78h.
// RL8: pixel bias bits 1-0 sink current reset 01; bit 2 external reference.
// RL9: gamma bit 4 stops converter switching during sensor sampling, reset 0.
// RL10: gamma bit 3 enables sensor sample-and-hold, 0 bypasses it, reset 0.
// RL11: gamma bits 2-0 sensor current reference divided by 2^(7-code), reset 0.
// RL12: host waits 10 ms after current change and samples only in blanking.
// RL13: supply mode bits 1-0 choose converter mode, reset 00; bits 3-2 sensor enable.
// RL14: auto mode one holds OLED current fixed from dimming and reference current.
// RL15: auto mode two regulates current, clamps at manual level threshold.
// RL16: manual level at 0Eh, reset 51h, used in modes 01 and 10.
// RL17: converter control bit 7 disables soft start when 1, reset 0.
// RL18: converter control bits 6-4 clock duty ratio, reset 3h, code 7h unused.
// RL19: converter control bits 3-2 clock frequency 125 to 800 kHz, reset 3.
// RL20: converter control bits 1-0 soft-start duration 2 to 16 ms, reset 1.
// RL21: register 0Dh maximum pixel voltage level, reset 0Dh.
// RL22: while global write protect is 1, host writes to the bank are ignored.
// RL23: unassigned bits read zero and ignore writes.
`define ADDR_RAMP_CONTROL      8'h06
`define ADDR_RAMP_AMP_CONTROL  8'h07
`define ADDR_RAMP_DAC_MAXIMUM  8'h08
`define ADDR_PIXEL_BIAS        8'h09
`define ADDR_GAMMA_SENSOR      8'h0A
`define ADDR_CATHODE_MODE      8'h0B
`define ADDR_CONVERTER_CONTROL 8'h0C
`define ADDR_MAX_PIXEL_VOLTAGE 8'h0D
`define ADDR_CATHODE_MANUAL    8'h0E
`define ADDR_FIRST             8'h06
`define NUM_REGS               9
`define MASK_RAMP_CONTROL      8'h1F
`define MASK_RAMP_AMP_CONTROL  8'h1F
`define MASK_RAMP_DAC_MAXIMUM  8'hFF
`define MASK_PIXEL_BIAS        8'h07
`define MASK_GAMMA_SENSOR      8'h1F
`define MASK_CATHODE_MODE      8'h0F
`define MASK_CONVERTER_CONTROL 8'hFF
`define MASK_MAX_PIXEL_VOLTAGE 8'hFF
`define MASK_CATHODE_MANUAL    8'hFF
`define RST_RAMP_CONTROL       8'h01
`define RST_RAMP_AMP_CONTROL   8'h04
`define RST_RAMP_DAC_MAXIMUM   8'h00
`define RST_PIXEL_BIAS         8'h01
`define RST_GAMMA_SENSOR       8'h00
`define RST_CATHODE_MODE       8'h00
`define RST_CONVERTER_CONTROL  8'h3D
`define RST_MAX_PIXEL_VOLTAGE  8'h0D
`define RST_CATHODE_MANUAL     8'h51
`define FLYBACK_SHORT_NS       500
`define FLYBACK_LONG_NS        800
`define CLK_PERIOD_NS          40
`define SENSOR_SETTLE_MS       10
`define SOFT_START_BASE_MS     2
`endif

// ==== analog_ctrl_pkg.sv ====
package analog_ctrl_pkg;
  typedef enum logic [1:0] {
    auto_current_mode_one = 2'h0,
    auto_clamped_mode_two = 2'h1,
    manual_mode           = 2'h2,
    mode_reserved         = 2'h3
  } cathode_mode_t;

  typedef struct packed {
    logic       counter_power_save;
    logic       ramp_force_high;
    logic       flyback_time_select;
    logic [1:0] ramp_start_shift;
    logic [9:0] flyback_cycles;
    logic       amp_output_monitor_en;
    logic       ramp_converter_monitor_en;
    logic [2:0] amp_bias_current;
    logic [7:0] ramp_peak_scale;
    logic       external_reference_select;
    logic [1:0] pixel_sink_current;
  } ramp_cfg_t;

  typedef struct packed {
    logic          converter_hold_en;
    logic          sensor_sample_hold_en;
    logic [2:0]    sensor_current_code;
    logic [7:0]    sensor_current_onehot;
    logic          sensor_settled;
    cathode_mode_t cathode_mode_field;
    logic [1:0]    current_sensor_en;
    logic          regulate_current;
    logic          clamp_at_level;
    logic          use_manual_level;
    logic [7:0]    cathode_manual_level;
    logic          soft_start_disable;
    logic [2:0]    converter_clock_duty;
    logic          duty_code_illegal;
    logic [1:0]    converter_clock_freq;
    logic [1:0]    soft_start_duration;
    logic [7:0]    max_pixel_voltage;
  } supply_cfg_t;
endpackage : analog_ctrl_pkg

// ==== analog_ctrl_regfile.sv ====
`timescale 1ns/10ps
`include "analog_ctrl_defines.svh"
module analog_ctrl_regfile
  import analog_ctrl_pkg::*;
#(
  parameter int NREGS = `NUM_REGS
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   clk_en,
  input  wire logic                   wr_en,
  input  wire logic [3:0]             wr_idx,
  input  wire logic [7:0]             wr_data,
  input  wire logic [3:0]             rd_idx,
  output logic      [7:0]             rd_data_ff,
  output logic      [NREGS*8-1:0]     regs_flat
);
  localparam logic [NREGS*8-1:0] MASKS = {
    `MASK_CATHODE_MANUAL, `MASK_MAX_PIXEL_VOLTAGE, `MASK_CONVERTER_CONTROL,
    `MASK_CATHODE_MODE, `MASK_GAMMA_SENSOR, `MASK_PIXEL_BIAS,
    `MASK_RAMP_DAC_MAXIMUM, `MASK_RAMP_AMP_CONTROL, `MASK_RAMP_CONTROL};
  localparam logic [NREGS*8-1:0] RESETS = {
    `RST_CATHODE_MANUAL, `RST_MAX_PIXEL_VOLTAGE, `RST_CONVERTER_CONTROL,
    `RST_CATHODE_MODE, `RST_GAMMA_SENSOR, `RST_PIXEL_BIAS,
    `RST_RAMP_DAC_MAXIMUM, `RST_RAMP_AMP_CONTROL, `RST_RAMP_CONTROL};

  genvar g;
  generate
    for (g = 0; g < NREGS; g++) begin : g_reg
      logic [7:0] reg_ff;
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          reg_ff <= RESETS[g*8 +: 8];
        end else if (clk_en && wr_en && wr_idx == 4'(g)) begin
          // RL23 mask unassigned bits
          reg_ff <= wr_data & MASKS[g*8 +: 8];
        end
      end
      assign regs_flat[g*8 +: 8] = reg_ff;
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_ff <= 8'h00;
    end else if (clk_en) begin
      rd_data_ff <= (rd_idx < 4'(NREGS)) ? regs_flat[rd_idx*8 +: 8] : 8'h00;
    end
  end
endmodule : analog_ctrl_regfile

// ==== cfg_host.sv ====
`timescale 1ns/10ps
module cfg_host (
  input  wire logic       clk,
  input  wire logic       sensor_settled,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // strobe stays up so writes can run back to back; idle or rd drops it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
  endtask : wr

  // released data line flips so a stale byte cannot look valid
  task automatic idle;
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
    @(negedge clk);
  endtask : idle

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_wr = 1'b0;
    reg_addr = a;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  task automatic program_nominal;
    wr(8'h08, 8'h78);
  endtask : program_nominal

  task automatic wait_settled(output int n);
    n = 0;
    while (sensor_settled !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_settled
endmodule : cfg_host
